// >>> logic/sfc_pkg.sv
// shared constants, command kinds and decode helpers for the serial
// flash command front end.
// assumes a 100 MHz core clock; no other surroundings needed.
package sfc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int OP_TIME_NS    = 10000;   // self-timed operation length
   localparam int OP_CYCLES     = OP_TIME_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////
   // opcodes
   localparam logic [7:0] OP_ARRAY_RD_LEG = 8'h68;
   localparam logic [7:0] OP_ARRAY_RD_SPI = 8'he8;
   localparam logic [7:0] OP_PAGE_RD_LEG  = 8'h52;
   localparam logic [7:0] OP_PAGE_RD_SPI  = 8'hd2;
   localparam logic [7:0] OP_BUF_RD_LEG   = 8'h54;
   localparam logic [7:0] OP_BUF_RD_SPI   = 8'hd4;
   localparam logic [7:0] OP_STAT_RD_LEG  = 8'h57;
   localparam logic [7:0] OP_STAT_RD_SPI  = 8'hd7;
   localparam logic [7:0] OP_BUF_WR       = 8'h84;
   localparam logic [7:0] OP_PROG_ERASE   = 8'h83;
   localparam logic [7:0] OP_PROG_NOERASE = 8'h88;
   localparam logic [7:0] OP_PAGE_ERASE   = 8'h81;
   localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
   localparam logic [7:0] OP_PAGE_PROG    = 8'h82;
   localparam logic [7:0] OP_XFER         = 8'h53;
   localparam logic [7:0] OP_COMPARE      = 8'h60;
   localparam logic [7:0] OP_REWRITE      = 8'h58;

   ////////////////////////////////////////////////////////////////////////
   // status byte layout and reset values
   localparam int         ST_READY_BIT = 7;
   localparam int         ST_CMP_BIT   = 6;
   localparam logic       MODE_RST     = 1'b1;   // mode 3 after reset
   localparam logic [2:0] BIT_LAST     = 3'h7;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_ARRAY_RD, CMD_PAGE_RD, CMD_BUF_RD, CMD_STAT_RD,
      CMD_BUF_WR, CMD_PROG_ERASE, CMD_PROG_NOERASE, CMD_PAGE_PROG,
      CMD_PAGE_ERASE, CMD_BLOCK_ERASE, CMD_XFER, CMD_COMPARE, CMD_REWRITE
   } sfc_cmd_e;

   // opcode to command kind; anything unknown maps to none
   function automatic sfc_cmd_e decode(input logic [7:0] op);
      case (op)
         OP_ARRAY_RD_LEG, OP_ARRAY_RD_SPI: decode = CMD_ARRAY_RD;
         OP_PAGE_RD_LEG,  OP_PAGE_RD_SPI:  decode = CMD_PAGE_RD;
         OP_BUF_RD_LEG,   OP_BUF_RD_SPI:   decode = CMD_BUF_RD;
         OP_STAT_RD_LEG,  OP_STAT_RD_SPI:  decode = CMD_STAT_RD;
         OP_BUF_WR:       decode = CMD_BUF_WR;
         OP_PROG_ERASE:   decode = CMD_PROG_ERASE;
         OP_PROG_NOERASE: decode = CMD_PROG_NOERASE;
         OP_PAGE_PROG:    decode = CMD_PAGE_PROG;
         OP_PAGE_ERASE:   decode = CMD_PAGE_ERASE;
         OP_BLOCK_ERASE:  decode = CMD_BLOCK_ERASE;
         OP_XFER:         decode = CMD_XFER;
         OP_COMPARE:      decode = CMD_COMPARE;
         OP_REWRITE:      decode = CMD_REWRITE;
         default:         decode = CMD_NONE;
      endcase
   endfunction

   // commands that run a self-timed operation after chip select rises
   function automatic logic is_timed(input sfc_cmd_e c);
      is_timed = c inside {CMD_PROG_ERASE, CMD_PROG_NOERASE, CMD_PAGE_PROG,
                           CMD_PAGE_ERASE, CMD_BLOCK_ERASE, CMD_XFER,
                           CMD_COMPARE, CMD_REWRITE};
   endfunction

   // commands that touch the flash array
   function automatic logic is_array(input sfc_cmd_e c);
      is_array = is_timed(c) || c inside {CMD_ARRAY_RD, CMD_PAGE_RD};
   endfunction

   // commands that touch the buffer
   function automatic logic is_buf(input sfc_cmd_e c);
      is_buf = c inside {CMD_BUF_RD, CMD_BUF_WR, CMD_PROG_ERASE,
                         CMD_PROG_NOERASE, CMD_PAGE_PROG, CMD_XFER,
                         CMD_COMPARE, CMD_REWRITE};
   endfunction

endpackage

// >>> logic/sfc_pair_buf.sv
// two-entry buffer with valid and ready on both sides.
// assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module sfc_pair_buf #(
   parameter int W = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic [W-1:0]      out_data_out
);

   typedef struct packed {
      logic [W-1:0] d0;   // head
      logic [W-1:0] d1;
      logic         v0;
      logic         v1;
   } sfc_buf_s;

   sfc_buf_s buf_reg;
   sfc_buf_s buf_next;
   logic     push;
   logic     pop;

   ////////////////////////////////////////////////////////////////////////
   // push and pop; ready is just "second slot free", so it is a flop
   always_comb begin
      buf_next = buf_reg;
      push     = in_valid_in && !buf_reg.v1;
      pop      = out_ready_in && buf_reg.v0;
      if (pop && push) begin
         if (buf_reg.v1) begin
            buf_next.d0 = buf_reg.d1;
            buf_next.d1 = in_data_in;
         end else begin
            buf_next.d0 = in_data_in;
         end
      end else if (pop) begin
         buf_next.d0 = buf_reg.d1;
         buf_next.v0 = buf_reg.v1;
         buf_next.v1 = 1'b0;
      end else if (push) begin
         if (!buf_reg.v0) begin
            buf_next.d0 = in_data_in;
            buf_next.v0 = 1'b1;
         end else begin
            buf_next.d1 = in_data_in;
            buf_next.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         buf_reg <= '0;
      end else begin
         buf_reg <= buf_next;
      end
   end

   assign in_ready_out  = !buf_reg.v1;
   assign out_valid_out = buf_reg.v0;
   assign out_data_out  = buf_reg.d0;

endmodule // sfc_pair_buf

// >>> logic/sfc_flash_ctl.sv
// serial flash command front end: link shifter on the serial clock,
// command decode, busy timing and clock mode select on the core clock.
// assumes a 100 MHz core clock, an unrelated serial clock that stands
// still outside frames, and an array engine that reports compare result.
// Contract
// RL1 - reset pin low aborts, forces idle
// RL2 - held in reset while pin low
// RL3 - busy pin low during self-timed operations
// RL4 - busy blocks array and used buffer
// RL5 - mode 3 after power-up or reset
// RL6 - serial output released after reset
// RL7 - chip select fall needed before opcode
// RL8 - chip select fall samples clock idle level
// RL9 - host waits 20 ms after power-up; the bench starts its first frame 5 clocks after reset release
// RL10 - decode read opcode pairs
// RL11 - 83h programs buffer with erase
// RL12 - 88h programs buffer without erase
// RL13 - decode 82h, 81h, 50h, 84h
// RL14 - capture rising, shift out falling
// RL15 - chip select rise ends operation
// RL16 - host avoids overlapping array operations
// RL17 - compare result into status bit 6
// RL18 - unknown opcode ignored, nothing changes
`timescale 1ns/1ns
module sfc_flash_ctl #(
   parameter logic [15:0] OP_CYCLES = 16'(sfc_pkg::OP_CYCLES),
   parameter int          W         = 8
) (
   input  wire logic         clk_in,
   input  wire logic         rst_b_in,
   input  wire logic         reset_pin_b_in,
   input  wire logic         cs_b_in,
   input  wire logic         sck_in,
   input  wire logic         si_in,
   output logic              so_out,
   output logic              so_oe_out,
   output logic              rdy_out,
   output logic              rdy_oe_out,
   output logic              mode3_out,
   output logic              cmd_valid_out,
   output logic [7:0]        cmd_code_out,
   output sfc_pkg::sfc_cmd_e cmd_kind_out,
   output logic              cmd_reject_out,
   output logic              op_start_out,
   output logic              cmp_out,
   input  wire logic         cmp_match_in,
   output logic              data_valid_out,
   input  wire logic         data_ready_in,
   output logic [W-1:0]      data_out
);

   ////////////////////////////////////////////////////////////////////////
   // link side, rising edge: opcode and data capture
   typedef struct packed {
      logic [2:0] bcnt;
      logic [6:0] sh;
      logic [7:0] rx;      // last whole byte, stable for 8 edges
      logic       tog;     // flips once per whole byte
      logic [7:0] op;
      logic       have_op;
   } sfc_lrise_s;

   sfc_lrise_s lr_reg;
   sfc_lrise_s lr_next;

   always_comb begin
      lr_next      = lr_reg;
      lr_next.sh   = {lr_reg.sh[5:0], si_in};      // see RL14
      lr_next.bcnt = lr_reg.bcnt + 3'h1;
      if (lr_reg.bcnt == sfc_pkg::BIT_LAST) begin
         lr_next.rx  = {lr_reg.sh, si_in};
         lr_next.tog = !lr_reg.tog;
         if (!lr_reg.have_op) begin
            lr_next.op      = {lr_reg.sh, si_in};
            lr_next.have_op = 1'b1;
         end
      end
   end

   // chip select high clears the frame; the clock may stop at any time
   always_ff @(posedge sck_in or posedge cs_b_in) begin
      if (cs_b_in) begin
         lr_reg <= '0;                              // see RL15
      end else begin
         lr_reg <= lr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link side, falling edge: status byte out
   typedef struct packed {
      logic [2:0] st_s1;   // {run, ready, compare}
      logic [2:0] st_s2;
      logic [6:0] obyte;
      logic [2:0] ocnt;
      logic       so;
      logic       so_oe;
   } sfc_lfall_s;

   sfc_lfall_s lf_reg;
   sfc_lfall_s lf_next;
   logic [2:0] st_core;
   logic       stat_cmd;
   logic [7:0] stat_byte;

   // status levels settle during the eight opcode clocks, long before use
   always_comb begin
      lf_next       = lf_reg;
      lf_next.st_s1 = st_core;
      lf_next.st_s2 = lf_reg.st_s1;
      stat_cmd      = lr_reg.have_op &&
                      (lr_reg.op == sfc_pkg::OP_STAT_RD_LEG ||
                       lr_reg.op == sfc_pkg::OP_STAT_RD_SPI);
      stat_byte     = '0;
      stat_byte[sfc_pkg::ST_READY_BIT] = lf_reg.st_s2[1];
      stat_byte[sfc_pkg::ST_CMP_BIT]   = lf_reg.st_s2[0];
      if (stat_cmd && lf_reg.st_s2[2]) begin        // see RL6
         if (!lf_reg.so_oe || lf_reg.ocnt == sfc_pkg::BIT_LAST) begin
            lf_next.so    = stat_byte[7];           // see RL14
            lf_next.obyte = stat_byte[6:0];
            lf_next.ocnt  = '0;
            lf_next.so_oe = 1'b1;
         end else begin
            lf_next.so    = lf_reg.obyte[6];
            lf_next.obyte = {lf_reg.obyte[5:0], 1'b0};
            lf_next.ocnt  = lf_reg.ocnt + 3'h1;
         end
      end
   end

   always_ff @(negedge sck_in or posedge cs_b_in) begin
      if (cs_b_in) begin
         lf_reg <= '0;                              // see RL15
      end else begin
         lf_reg <= lf_next;
      end
   end

   assign so_out    = lf_reg.so;
   assign so_oe_out = lf_reg.so_oe;

   ////////////////////////////////////////////////////////////////////////
   // core side state
   typedef struct packed {
      logic              rp_s1;
      logic              rp_s2;
      logic              cs_s1;
      logic              cs_s2;
      logic              cs_d;
      logic              sck_s1;
      logic              sck_s2;
      logic              tog_s1;
      logic              tog_s2;
      logic              tog_d;
      logic              in_frame;
      logic              first;
      sfc_pkg::sfc_cmd_e cmd;        // accepted command of this frame
      logic              mode3;
      logic              busy;
      logic              busy_buf;
      logic              busy_cmp;
      logic [15:0]       cnt;
      logic              cmp;
      logic              cmd_valid;
      logic [7:0]        code;
      sfc_pkg::sfc_cmd_e kind;
      logic              reject;
      logic              op_start;
      logic              pend_v;
      logic [W-1:0]      pend_d;
      logic [2:0]        st;
   } sfc_core_s;

   sfc_core_s         c_reg;
   sfc_core_s         c_next;
   logic              cs_fall;
   logic              cs_rise;
   logic              byte_evt;
   logic              blocked;
   logic              buf_ready;
   sfc_pkg::sfc_cmd_e dec;

   always_comb begin
      c_next          = c_reg;
      c_next.rp_s1    = reset_pin_b_in;
      c_next.rp_s2    = c_reg.rp_s1;
      c_next.cs_s1    = cs_b_in;
      c_next.cs_s2    = c_reg.cs_s1;
      c_next.cs_d     = c_reg.cs_s2;
      c_next.sck_s1   = sck_in;
      c_next.sck_s2   = c_reg.sck_s1;
      c_next.tog_s1   = lr_reg.tog;
      c_next.tog_s2   = c_reg.tog_s1;
      c_next.tog_d    = c_reg.tog_s2;
      c_next.cmd_valid = 1'b0;
      c_next.reject   = 1'b0;
      c_next.op_start = 1'b0;
      cs_fall  = c_reg.cs_d && !c_reg.cs_s2;
      cs_rise  = !c_reg.cs_d && c_reg.cs_s2;
      byte_evt = c_reg.tog_s2 != c_reg.tog_d;
      dec      = sfc_pkg::decode(lr_reg.rx);
      blocked  = c_reg.busy && (sfc_pkg::is_array(dec) ||
                 (sfc_pkg::is_buf(dec) && c_reg.busy_buf));   // see RL4
      if (c_reg.pend_v && buf_ready) begin
         c_next.pend_v = 1'b0;
      end
      if (!c_reg.rp_s2) begin
         // abort, go idle, stay there while the pin is low
         c_next.in_frame = 1'b0;                    // see RL1
         c_next.first    = 1'b0;                    // see RL2
         c_next.cmd      = sfc_pkg::CMD_NONE;
         c_next.busy     = 1'b0;                    // see RL1
         c_next.busy_buf = 1'b0;
         c_next.busy_cmp = 1'b0;
         c_next.mode3    = sfc_pkg::MODE_RST;       // see RL5
         c_next.pend_v   = 1'b0;
      end else begin
         // a fall seen after release is the only way into a frame
         if (cs_fall) begin
            c_next.in_frame = 1'b1;                 // see RL7
            c_next.first    = 1'b1;
            c_next.cmd      = sfc_pkg::CMD_NONE;
            c_next.mode3    = c_reg.sck_s2;         // see RL8
         end else if (cs_rise) begin
            c_next.in_frame = 1'b0;                 // see RL15
            c_next.first    = 1'b0;
            c_next.cmd      = sfc_pkg::CMD_NONE;
            if (c_reg.in_frame && sfc_pkg::is_timed(c_reg.cmd)) begin
               c_next.busy     = 1'b1;              // see RL3
               c_next.busy_buf = sfc_pkg::is_buf(c_reg.cmd);
               c_next.busy_cmp = c_reg.cmd == sfc_pkg::CMD_COMPARE;
               c_next.cnt      = OP_CYCLES - 16'h0001;
               c_next.op_start = 1'b1;
            end
         end else if (byte_evt && c_reg.in_frame) begin
            if (c_reg.first) begin
               // first byte is the opcode: 68/e8, 52/d2, 54/d4, 57/d7
               c_next.first     = 1'b0;             // see RL10
               c_next.cmd_valid = 1'b1;             // see RL11
               c_next.code      = lr_reg.rx;        // see RL12
               c_next.kind      = dec;              // see RL13
               c_next.reject    = blocked;
               c_next.cmd       = blocked ? sfc_pkg::CMD_NONE : dec;
            end else if (c_reg.cmd != sfc_pkg::CMD_NONE) begin
               // unknown or refused commands forward nothing
               c_next.pend_v = 1'b1;                // see RL18
               c_next.pend_d = W'(lr_reg.rx);
            end
         end
         if (c_reg.busy) begin
            if (c_reg.cnt == 16'h0000) begin
               c_next.busy     = 1'b0;
               c_next.busy_buf = 1'b0;
               c_next.busy_cmp = 1'b0;
               if (c_reg.busy_cmp) begin
                  c_next.cmp = cmp_match_in;        // see RL17
               end
            end else begin
               c_next.cnt = c_reg.cnt - 16'h0001;
            end
         end
      end
      c_next.st = {c_reg.rp_s2, !c_next.busy, c_next.cmp};
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         c_reg       <= '0;
         c_reg.rp_s1 <= 1'b1;
         c_reg.rp_s2 <= 1'b1;
         c_reg.cs_s1 <= 1'b1;
         c_reg.cs_s2 <= 1'b1;
         c_reg.cs_d  <= 1'b1;                       // no false rise
         c_reg.mode3 <= sfc_pkg::MODE_RST;          // see RL5
      end else begin
         c_reg <= c_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // received data bytes: a stalled reader costs no word up to three deep
   sfc_pair_buf #(
      .W(W)
   ) u_buf (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (c_reg.pend_v),
      .in_ready_out  (buf_ready),
      .in_data_in    (c_reg.pend_d),
      .out_valid_out (data_valid_out),
      .out_ready_in  (data_ready_in),
      .out_data_out  (data_out)
   );

   // open-drain busy: driven low only while an operation runs
   assign st_core        = c_reg.st;
   assign rdy_out        = 1'b0;
   assign rdy_oe_out     = c_reg.busy;              // see RL3
   assign mode3_out      = c_reg.mode3;
   assign cmd_valid_out  = c_reg.cmd_valid;
   assign cmd_code_out   = c_reg.code;
   assign cmd_kind_out   = c_reg.kind;
   assign cmd_reject_out = c_reg.reject;
   assign op_start_out   = c_reg.op_start;
   assign cmp_out        = c_reg.cmp;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   a_reset_idle: assert property (                 // see RL1
      !c_reg.rp_s2 |=> !rdy_oe_out && !c_reg.in_frame)
      else $error("reset pin did not force idle");
   a_reset_hold: assert property (                 // see RL2
      !c_reg.rp_s2 ##1 !c_reg.rp_s2 |-> !cmd_valid_out && !op_start_out)
      else $error("command taken while in reset");
   a_busy_start: assert property (                 // see RL3
      op_start_out |-> rdy_oe_out [*2])
      else $error("busy pin not low after operation start");
   a_busy_block: assert property (                 // see RL4
      c_reg.busy && byte_evt && c_reg.in_frame && c_reg.first &&
      c_reg.rp_s2 && !cs_fall && !cs_rise &&
      (sfc_pkg::is_array(dec) || (sfc_pkg::is_buf(dec) && c_reg.busy_buf))
      |=> cmd_valid_out && cmd_reject_out)
      else $error("array or busy buffer command not refused while busy");
   a_reset_mode: assert property (                 // see RL5
      !c_reg.rp_s2 |=> mode3_out)
      else $error("mode not 3 after reset");
   a_mode_pick: assert property (                  // see RL8
      cs_fall && c_reg.rp_s2 |=> mode3_out == $past(c_reg.sck_s2))
      else $error("mode not taken from clock idle level");
   a_opcode_decode: assert property (              // see RL10
      cmd_valid_out |-> cmd_kind_out == sfc_pkg::decode(cmd_code_out))
      else $error("opcode decoded wrongly");
   a_frame_first: assert property (                // see RL7
      $rose(cmd_valid_out) |-> $past(c_reg.in_frame))
      else $error("opcode taken outside a frame");
   a_frame_end: assert property (                  // see RL15
      cs_rise && c_reg.rp_s2 |=> !c_reg.in_frame)
      else $error("frame not ended by chip select rise");
   a_cmp_store: assert property (                  // see RL17
      c_reg.busy && c_reg.busy_cmp && c_reg.cnt == 16'h0000 && c_reg.rp_s2
      |=> cmp_out == $past(cmp_match_in) && !rdy_oe_out)
      else $error("compare result not stored");
   a_unknown_quiet: assert property (              // see RL18
      c_reg.in_frame && c_reg.cmd == sfc_pkg::CMD_NONE && !c_reg.busy
      && cs_rise |=> !rdy_oe_out && !op_start_out)
      else $error("unknown opcode started an operation");

   c_busy_run:   cover property (op_start_out ##[1:1000] !rdy_oe_out);
   c_refused:    cover property (cmd_reject_out);
   c_stat_read:  cover property (cmd_valid_out &&
                                 cmd_kind_out == sfc_pkg::CMD_STAT_RD);
   c_data_stall: cover property (data_valid_out && !data_ready_in [*3]);

endmodule // sfc_flash_ctl

// >>> tb/sfc_host.sv
// host model for the serial link: chip select, serial clock, data in.
// assumes the device drives so only while so_oe is high.
`timescale 1ns/1ns
module sfc_host (
   output logic      cs_b_out,
   output logic      sck_out,
   output logic      si_out,
   input  wire logic so_in,
   input  wire logic so_oe_in
);
   logic       idle;
   logic       drove;   // so_oe seen high in this frame
   logic [7:0] rx;
   ////////////////////////////////////////
   // the clock stands still at its idle level while deselected
   initial begin
      cs_b_out = 1'b0;
      sck_out  = 1'b1;
      si_out   = 1'b0;
      idle     = 1'b1;
      drove    = 1'b0;
      rx       = 8'h00;
      // a clean rise clears the link flops, which have no other reset
      #1 cs_b_out = 1'b1;
   end
   // idle level sets the mode; the fall comes before any opcode
   task automatic start(input logic lvl);
      sck_out = lvl;
      idle    = lvl;
      drove   = 1'b0;
      #64 cs_b_out = 1'b0;
      #64;
   endtask
   // msb first: drive after the fall, sample on the rise
   task automatic xfer(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sck_out = 1'b0;
         si_out  = b[i];
         #32 sck_out = 1'b1;
         rx = {rx[6:0], so_oe_in ? so_in : ~rx[0]};
         drove = drove | so_oe_in;
         #32;
      end
   endtask
   // si flips after the frame so a stale bit is never trusted
   task automatic stop();
      if (!idle) begin
         sck_out = 1'b0;
         #32;
      end
      cs_b_out = 1'b1;
      si_out   = ~si_out;
      #64;
   endtask
endmodule // sfc_host

// >>> tb/tb.sv
// bench for the command front end: random frames, busy and reset cases.
// assumes sfc_host drives the link and the package is compiled first.
`timescale 1ns/1ns
module tb;
   localparam logic [15:0] OPC = 16'h0190; // outlasts two frames
   logic        clk_in, rst_b_in, reset_pin_b_in, cs_b_in, sck_in, si_in;
   logic        so_out, so_oe_out, rdy_out, rdy_oe_out, mode3_out;
   logic        cmd_valid_out, cmd_reject_out, op_start_out, cmp_out;
   logic        cmp_match_in, data_valid_out, data_ready_in;
   logic [7:0]  cmd_code_out, data_out, c_code;
   logic [7:0]  sent[$], got[$];
   logic [3:0]  c_kind;
   logic        seen, c_rej, c_mode, stall, cmp_exp;
   logic [31:0] seed = 32'h0000_0043;
   int          busy_cnt, starts, err_total, samples_checked;
   sfc_pkg::sfc_cmd_e cmd_kind_out;
   wire         rdy_line = rdy_oe_out ? rdy_out : 1'b1; // pull-up
   logic [7:0]  ops[18] = '{8'h68, 8'he8, 8'h52, 8'hd2, 8'h54, 8'hd4,
      8'h57, 8'hd7, 8'h84, 8'h83, 8'h88, 8'h82, 8'h81, 8'h50, 8'h53,
      8'h60, 8'h58, 8'h00};

   sfc_flash_ctl #(.OP_CYCLES(OPC)) dut (.clk_in, .rst_b_in,
      .reset_pin_b_in, .cs_b_in, .sck_in, .si_in, .so_out, .so_oe_out,
      .rdy_out, .rdy_oe_out, .mode3_out, .cmd_valid_out, .cmd_code_out,
      .cmd_kind_out, .cmd_reject_out, .op_start_out, .cmp_out,
      .cmp_match_in, .data_valid_out, .data_ready_in, .data_out);
   sfc_host host (.cs_b_out(cs_b_in), .sck_out(sck_in), .si_out(si_in),
      .so_in(so_out), .so_oe_in(so_oe_out));

   ////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // table order: read pairs, then one kind per opcode, unknown last
   function automatic logic [3:0] exp_kind(input int i);
      if (i == 17) return 4'h0;
      return (i < 8) ? 4'(i / 2 + 1) : 4'(i - 3);
   endfunction
   task automatic chk(input string what, input logic [15:0] exp, got);
      samples_checked++;
      if (exp !== got) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic frame(input logic [7:0] op, input int n, input bit fwd,
                        input logic lvl);
      logic [7:0] b;
      seen = 1'b0;
      host.start(lvl);
      host.xfer(op);
      for (int k = 0; k < n; k++) begin
         b = 8'(rnd());
         if (fwd) sent.push_back(b);
         host.xfer(b);
      end
      host.stop();
      if (seen) chk("mode", lvl, c_mode);
   endtask
   task automatic drain();
      repeat (40) @(posedge clk_in);
      chk("count", 16'(sent.size()), 16'(got.size()));
      while (sent.size() > 0 && got.size() > 0)
         chk("byte", sent.pop_front(), got.pop_front());
      sent.delete();
      got.delete();
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 3000 && rdy_oe_out === 1'b1; k++)
         @(posedge clk_in);
   endtask

   // clock and watchdog (whole run is well under 100 us)
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #300000;
      err_total++;
      close_out();
   end
   // capture of pulses, busy length and taken bytes; random consumer
   always @(posedge clk_in) begin
      if (cmd_valid_out === 1'b1) begin
         seen   <= 1'b1;
         c_code <= cmd_code_out;
         c_kind <= cmd_kind_out;
         c_rej  <= cmd_reject_out;
         c_mode <= mode3_out;
      end
      if (rdy_line === 1'b0) busy_cnt <= busy_cnt + 1;
      if (op_start_out === 1'b1) starts <= starts + 1;
      if (data_valid_out === 1'b1 && data_ready_in) got.push_back(data_out);
      data_ready_in <= ~stall & 1'(rnd());
   end
   ////////////////////////////////////////
   initial begin
      rst_b_in = 1'b0;
      reset_pin_b_in = 1'b1;
      cmp_match_in = 1'b0;
      data_ready_in = 1'b0;
      stall = 1'b0;
      cmp_exp = 1'b0;
      seen = 1'b0;
      repeat (16) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (4) @(posedge clk_in); // settle before first command
      chk("mode3", 1, mode3_out);
      chk("so_oe", 0, so_oe_out);
      chk("busy", 0, rdy_oe_out);
      for (int i = 0; i < 18; i++) begin
         @(posedge clk_in);
         cmp_match_in <= 1'(rnd());
         busy_cnt = 0;
         starts = 0;
         frame(ops[i], 1, i != 17, 1'(rnd()));
         chk("seen", 1, seen);
         chk("code", ops[i], c_code);
         chk("kind", exp_kind(i), c_kind);
         chk("so_oe", 0, so_oe_out);
         if (i == 6 || i == 7)
            chk("status", {1'b1, cmp_exp, 6'h00}, host.rx);
         if (i >= 9 && i <= 16) begin
            frame(8'hd7, 1, 1, 1'b0);
            chk("ready bit", 0, host.rx[7]);
            frame((i == 12 || i == 13) ? 8'h84 : 8'h54, 1,
                  i == 12 || i == 13, 1'b1);
            chk("reject", (i == 12 || i == 13) ? 0 : 1, c_rej);
         end
         wait_idle();
         chk("busy len", (i >= 9 && i <= 16) ? OPC : 16'h0000,
             16'(busy_cnt));
         chk("starts", (i >= 9 && i <= 16) ? 1 : 0, 16'(starts));
         if (i == 15) cmp_exp = cmp_match_in;
         chk("cmp", cmp_exp, cmp_out);
         drain();
      end
      // three bytes under a full stall must all survive
      stall = 1'b1;
      frame(8'h84, 3, 1, 1'b0);
      stall = 1'b0;
      drain();
      // reset pin in mid-operation, a frame ignored while held, then recovery
      frame(8'h83, 1, 1, 1'b0);
      drain();
      reset_pin_b_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      chk("abort", 0, rdy_oe_out);
      chk("mode3", 1, mode3_out);
      frame(8'hd7, 1, 0, 1'b0);
      chk("held", 0, seen);
      chk("so_oe", 0, host.drove);
      @(posedge clk_in);
      reset_pin_b_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      frame(8'hd7, 1, 0, 1'b1);
      chk("resume", {1'b1, cmp_exp, 6'h00}, host.rx);
      close_out();
   end
endmodule // tb
